/* File: src/flag_if.sv */
`timescale 1ns/100ps
// ****************************************************************
// conversion results in, status bytes out
// ****************************************************************
interface flag_if;
   logic       conv_done;
   logic [2:0] conv_channel;
   logic       conv_alert;
   logic       conv_over;
   logic       conv_fault;
   logic [7:0] status1;
   logic [7:0] overtemp_status;
   logic [7:0] diode_fault_status;

   modport source (
      output conv_done, conv_channel, conv_alert, conv_over, conv_fault,
      input  status1, overtemp_status, diode_fault_status
   );
   modport flags (
      input  conv_done, conv_channel, conv_alert, conv_over, conv_fault,
      output status1, overtemp_status, diode_fault_status
   );
endinterface : flag_if

/* File: src/status_flags.sv */
`timescale 1ns/100ps
module status_flags (
   input wire logic clock,
   input wire logic rst_n,
   flag_if.flags    fi
);
   logic [thermal_pkg::REMOTE_COUNT-1:0] hit;
   logic [thermal_pkg::REMOTE_COUNT-1:0] alert;
   logic [thermal_pkg::REMOTE_COUNT-1:0] fault;
   logic                                 local_alert;
   logic                                 ch1_overtemp_flag;
   logic                                 ch4_overtemp_flag;
   logic                                 por_done;

   // ****************************************************************
   // per-channel update strobes
   // ****************************************************************
   genvar i;
   generate
      for (i = 0; i < thermal_pkg::REMOTE_COUNT; i++) begin : g_hit
         assign hit[i] = fi.conv_done && (fi.conv_channel == 3'(i + 1));
      end
   endgenerate

   // flags follow the latest result; a status read never clears them
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         alert <= '0;
         fault <= '0;
      end else begin
         alert <= (alert & ~hit) | (hit & {thermal_pkg::REMOTE_COUNT{fi.conv_alert}});
         fault <= (fault & ~hit) | (hit & {thermal_pkg::REMOTE_COUNT{fi.conv_fault}});
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         local_alert <= 1'b0;
      end else if (fi.conv_done && fi.conv_channel == thermal_pkg::CHAN_LOCAL) begin
         local_alert <= fi.conv_alert;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ch1_overtemp_flag <= 1'b0;
         ch4_overtemp_flag <= 1'b0;
      end else if (fi.conv_done) begin
         if (fi.conv_channel == thermal_pkg::CHAN_REMOTE1) begin
            ch1_overtemp_flag <= fi.conv_over;
         end
         if (fi.conv_channel == thermal_pkg::CHAN_REMOTE4) begin
            ch4_overtemp_flag <= fi.conv_over;
         end
      end
   end

   // unused bits read 0 only until the first edge after reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         por_done <= 1'b0;
      end else begin
         por_done <= 1'b1;
      end
   end

   // ****************************************************************
   // status byte assembly
   // ****************************************************************
   always_comb begin
      fi.status1            = thermal_pkg::STATUS_RESET;
      fi.overtemp_status    = thermal_pkg::STATUS_RESET;
      fi.diode_fault_status = thermal_pkg::STATUS_RESET;
      fi.status1[thermal_pkg::BIT_ALERT_LO +: thermal_pkg::REMOTE_COUNT] = alert;
      fi.status1[thermal_pkg::BIT_LOCAL_ALERT]      = local_alert;
      fi.overtemp_status[thermal_pkg::BIT_CH1_OVER] = ch1_overtemp_flag;
      fi.overtemp_status[thermal_pkg::BIT_CH4_OVER] = ch4_overtemp_flag;
      fi.diode_fault_status[thermal_pkg::BIT_FAULT_LO +: thermal_pkg::REMOTE_COUNT] = fault;
      fi.diode_fault_status[thermal_pkg::BIT_UNUSED_LO] = por_done;
      fi.diode_fault_status[thermal_pkg::BIT_UNUSED_HI] = por_done;
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_ch4_over_set: assert property (
      fi.conv_done && fi.conv_channel == thermal_pkg::CHAN_REMOTE4 && fi.conv_over
      |=> fi.overtemp_status[thermal_pkg::BIT_CH4_OVER])
      else $error("channel 4 overtemp flag not set");

   a_ch1_over_set: assert property (
      fi.conv_done && fi.conv_channel == thermal_pkg::CHAN_REMOTE1 && fi.conv_over
      |=> fi.overtemp_status[thermal_pkg::BIT_CH1_OVER])
      else $error("channel 1 overtemp flag not set");

   a_fault_bit_tracks: assert property (
      fi.conv_done && fi.conv_channel == thermal_pkg::CHAN_REMOTE4
      |=> fi.diode_fault_status[thermal_pkg::BIT_FAULT_LO + 3] == $past(fi.conv_fault))
      else $error("channel 4 diode fault bit wrong");

   a_unused_after_por: assert property (
      $rose(rst_n) |-> fi.diode_fault_status[thermal_pkg::BIT_UNUSED_HI -: 2] == 2'b00
      ##1 fi.diode_fault_status[thermal_pkg::BIT_UNUSED_HI -: 2] == 2'b11 [*3])
      else $error("unused status bits wrong after reset");

   a_local_alert_tracks: assert property (
      fi.conv_done && fi.conv_channel == thermal_pkg::CHAN_LOCAL
      |=> fi.status1[thermal_pkg::BIT_LOCAL_ALERT] == $past(fi.conv_alert))
      else $error("local alert flag wrong");

   a_flags_hold_idle: assert property (
      !fi.conv_done |=> $stable(fi.status1) && $stable(fi.overtemp_status))
      else $error("status changed without a conversion");

endmodule : status_flags

/* File: src/thermal_pkg.sv */
// ****************************************************************
// temperature monitor status constants
// ****************************************************************
package thermal_pkg;

   // ****************************************************************
   // 7-bit slave addresses, one per part variant
   // ****************************************************************
   localparam logic [6:0] ADDR_VARIANT_A = 7'h1a;
   localparam logic [6:0] ADDR_VARIANT_B = 7'h1c;
   localparam logic [6:0] ADDR_VARIANT_C = 7'h4c;
   localparam logic [6:0] ADDR_VARIANT_D = 7'h4e;

   // ****************************************************************
   // register pointers
   // ****************************************************************
   localparam logic [7:0] OFFSET_CONFIG3     = 8'h43;
   localparam logic [7:0] OFFSET_STATUS1     = 8'h44;
   localparam logic [7:0] OFFSET_OVERTEMP    = 8'h45;
   localparam logic [7:0] OFFSET_DIODE_FAULT = 8'h46;
   localparam logic [7:0] UNMAPPED_READ      = 8'h00;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int BIT_LOCAL_ALERT = 6;
   localparam int BIT_ALERT_LO    = 0;
   localparam int BIT_CH1_OVER    = 0;
   localparam int BIT_CH4_OVER    = 3;
   localparam int BIT_FAULT_LO    = 1;
   localparam int BIT_UNUSED_LO   = 5;
   localparam int BIT_UNUSED_HI   = 6;
   localparam int BIT_MASK_CH1    = 0;
   localparam int BIT_MASK_CH4    = 3;

   // ****************************************************************
   // reset values, channel codes, framing
   // ****************************************************************
   localparam logic [7:0] STATUS_RESET  = 8'h00;
   localparam logic [7:0] CONFIG_RESET  = 8'h00;
   localparam int         REMOTE_COUNT  = 4;
   localparam logic [2:0] CHAN_LOCAL    = 3'h0;
   localparam logic [2:0] CHAN_REMOTE1  = 3'h1;
   localparam logic [2:0] CHAN_REMOTE4  = 3'h4;
   localparam logic [3:0] BYTE_BITS     = 4'h8;

endpackage : thermal_pkg

/* File: src/thermal_status_flags.sv */
`timescale 1ns/100ps
// Behaviour
// - channel 4 over limit sets overtemp bit 3
// - channel 1 over limit sets overtemp bit 0
// - fault bits 1-4 flag shorted/open diode pins
// - fault bits 6,5 read 0, then 1
// - answer only the variant's fixed slave address
// - config bits 3,0 mask overtemp output
// - alert register: remote bits 0-3, local bit 6
// - faulted channel reported and skipped in sequence
module thermal_status_flags #(
   parameter logic [6:0] SLAVE_ADDR = thermal_pkg::ADDR_VARIANT_A
) (
   input  wire logic       CLOCK,
   input  wire logic       RST_N,
   input  wire logic       SCL,
   input  wire logic       SDA_IN,
   output logic            SDA_OUT,
   output logic            SDA_OE,
   input  wire logic       CONV_DONE,
   input  wire logic [2:0] CONV_CHANNEL,
   input  wire logic       CONV_ALERT_HIGH,
   input  wire logic       CONV_OVERTEMP_HIGH,
   input  wire logic       CONV_DIODE_FAULT,
   output logic            OVERTEMP_OUTPUT,
   output logic            OVERTEMP_OUTPUT_OE,
   output logic [3:0]      CHANNEL_SKIP
);
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_RX, S_TX, S_MACK} state_t;

   state_t     state;
   logic       scl_meta;
   logic       scl_sync;
   logic       scl_prev;
   logic       sda_meta;
   logic       sda_sync;
   logic       sda_prev;
   logic       scl_rise;
   logic       scl_fall;
   logic       bus_start;
   logic       bus_stop;
   logic [3:0] bit_count;
   logic [7:0] shift;
   logic [7:0] tx_shift;
   logic       is_read;
   logic       have_pointer;
   logic [7:0] pointer;
   logic       ch1_overtemp_mask;
   logic       ch4_overtemp_mask;
   logic [7:0] config3;
   logic [7:0] read_data;
   logic       byte_in_done;

   flag_if fi ();

   assign fi.conv_done    = CONV_DONE;
   assign fi.conv_channel = CONV_CHANNEL;
   assign fi.conv_alert   = CONV_ALERT_HIGH;
   assign fi.conv_over    = CONV_OVERTEMP_HIGH;
   assign fi.conv_fault   = CONV_DIODE_FAULT;

   status_flags u_flags (
      .clock (CLOCK),
      .rst_n (RST_N),
      .fi    (fi.flags)
   );

   // ****************************************************************
   // pin synchronisers and bus events
   // ****************************************************************
   // idle bus is high, so the chain resets high to avoid a false start
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         scl_prev <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_meta <= SCL;
         scl_sync <= scl_meta;
         scl_prev <= scl_sync;
         sda_meta <= SDA_IN;
         sda_sync <= sda_meta;
         sda_prev <= sda_sync;
      end
   end

   assign scl_rise     = scl_sync && !scl_prev;
   assign scl_fall     = !scl_sync && scl_prev;
   assign bus_start    = scl_sync && scl_prev && sda_prev && !sda_sync;
   assign bus_stop     = scl_sync && scl_prev && !sda_prev && sda_sync;
   assign byte_in_done = scl_fall && (bit_count == thermal_pkg::BYTE_BITS);

   // ****************************************************************
   // register read mux
   // ****************************************************************
   always_comb begin
      config3 = thermal_pkg::CONFIG_RESET;
      config3[thermal_pkg::BIT_MASK_CH1] = ch1_overtemp_mask;
      config3[thermal_pkg::BIT_MASK_CH4] = ch4_overtemp_mask;
      unique case (pointer)
         thermal_pkg::OFFSET_STATUS1: read_data = fi.status1;
         thermal_pkg::OFFSET_OVERTEMP:    read_data = fi.overtemp_status;
         thermal_pkg::OFFSET_DIODE_FAULT: read_data = fi.diode_fault_status;
         thermal_pkg::OFFSET_CONFIG3: read_data = config3;
         default:                     read_data = thermal_pkg::UNMAPPED_READ;
      endcase
   end

   // ****************************************************************
   // slave state machine
   // ****************************************************************
   // open drain: sda_oe high pulls the line low, so a 1 bit is a release
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         state        <= S_IDLE;
         bit_count    <= '0;
         shift        <= '0;
         tx_shift     <= '0;
         is_read      <= 1'b0;
         have_pointer <= 1'b0;
         SDA_OE       <= 1'b0;
      end else if (bus_start) begin
         state        <= S_ADDR;
         bit_count    <= '0;
         have_pointer <= 1'b0;
         SDA_OE       <= 1'b0;
      end else if (bus_stop) begin
         state  <= S_IDLE;
         SDA_OE <= 1'b0;
      end else begin
         unique case (state)
            S_IDLE: begin
               bit_count <= '0;
            end
            S_ADDR, S_RX: begin
               if (scl_rise) begin
                  shift     <= {shift[6:0], sda_sync};
                  bit_count <= bit_count + 4'h1;
               end else if (byte_in_done) begin
                  bit_count <= '0;
                  if (state == S_RX) begin
                     state        <= S_ACK;
                     SDA_OE       <= 1'b1;
                     have_pointer <= 1'b1;
                  end else if (shift[7:1] == SLAVE_ADDR) begin
                     state   <= S_ACK;
                     SDA_OE  <= 1'b1;
                     is_read <= shift[0];
                  end else begin
                     state <= S_IDLE;
                  end
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  if (is_read) begin
                     state    <= S_TX;
                     tx_shift <= read_data;
                     SDA_OE   <= !read_data[7];
                  end else begin
                     state  <= S_RX;
                     SDA_OE <= 1'b0;
                  end
               end
            end
            S_TX: begin
               if (scl_rise) begin
                  bit_count <= bit_count + 4'h1;
               end else if (scl_fall) begin
                  if (bit_count == thermal_pkg::BYTE_BITS) begin
                     state     <= S_MACK;
                     bit_count <= '0;
                     SDA_OE    <= 1'b0;
                  end else begin
                     tx_shift <= {tx_shift[6:0], 1'b0};
                     SDA_OE   <= !tx_shift[6];
                  end
               end
            end
            S_MACK: begin
               // master nack ends the read; ack repeats the same register
               if (scl_rise && sda_sync) begin
                  state <= S_IDLE;
               end else if (scl_fall) begin
                  state    <= S_TX;
                  tx_shift <= read_data;
                  SDA_OE   <= !read_data[7];
               end
            end
         endcase
      end
   end

   // ****************************************************************
   // pointer and mask writes
   // ****************************************************************
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         pointer           <= thermal_pkg::OFFSET_STATUS1;
         ch1_overtemp_mask <= 1'b0;
         ch4_overtemp_mask <= 1'b0;
      end else if (!bus_start && !bus_stop && state == S_RX && byte_in_done) begin
         if (!have_pointer) begin
            pointer <= shift;
         end else if (pointer == thermal_pkg::OFFSET_CONFIG3) begin
            ch1_overtemp_mask <= shift[thermal_pkg::BIT_MASK_CH1];
            ch4_overtemp_mask <= shift[thermal_pkg::BIT_MASK_CH4];
         end
      end
   end

   // ****************************************************************
   // pin outputs
   // ****************************************************************
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         SDA_OUT            <= 1'b0;
         OVERTEMP_OUTPUT    <= 1'b0;
         OVERTEMP_OUTPUT_OE <= 1'b0;
         CHANNEL_SKIP       <= '0;
      end else begin
         SDA_OUT            <= 1'b0;
         OVERTEMP_OUTPUT    <= 1'b0;
         OVERTEMP_OUTPUT_OE <= (fi.overtemp_status[thermal_pkg::BIT_CH1_OVER]
                                && !ch1_overtemp_mask)
                            || (fi.overtemp_status[thermal_pkg::BIT_CH4_OVER]
                                && !ch4_overtemp_mask);
         // sequencer skips any faulted remote channel, open or shorted alike
         CHANNEL_SKIP       <=
            fi.diode_fault_status[thermal_pkg::BIT_FAULT_LO +: thermal_pkg::REMOTE_COUNT];
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   sequence addr_byte_seen;
      !bus_start && !bus_stop && state == S_ADDR && byte_in_done;
   endsequence

   a_addr_mismatch_quiet: assert property (
      addr_byte_seen ##0 (shift[7:1] != SLAVE_ADDR) |=> state == S_IDLE && !SDA_OE [*2])
      else $error("responded to a foreign address");

   a_addr_match_ack: assert property (
      addr_byte_seen ##0 (shift[7:1] == SLAVE_ADDR) |=> SDA_OE && state == S_ACK)
      else $error("own address not acknowledged");

   a_overtemp_masked: assert property (
      ##1 OVERTEMP_OUTPUT_OE ==
      (($past(fi.overtemp_status[thermal_pkg::BIT_CH1_OVER]) && !$past(ch1_overtemp_mask))
      || ($past(fi.overtemp_status[thermal_pkg::BIT_CH4_OVER]) && !$past(ch4_overtemp_mask))))
      else $error("overtemp output disagrees with flags and masks");

   a_skip_follows_fault: assert property (
      CONV_DONE && CONV_CHANNEL == thermal_pkg::CHAN_REMOTE1 && CONV_DIODE_FAULT
      |=> ##1 CHANNEL_SKIP[0])
      else $error("faulted channel 1 not skipped");

endmodule : thermal_status_flags

/* File: testbench/smbus_host.sv */
`timescale 1ns/100ps
// ****************************************************************
// smbus host: open-drain data, scl driven by the host alone
// ****************************************************************
module smbus_host (
   input  wire logic clock,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   localparam int HALF = 10;   // scl phases kept above 8 clocks

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick

   // also a repeated start: data released while scl is still low
   task automatic start_cond();
      sda_low <= 1'b0;
      tick(HALF / 2);
      scl <= 1'b1;
      tick(HALF);
      sda_low <= 1'b1;
      tick(HALF);
      scl <= 1'b0;
      tick(HALF / 2);
   endtask : start_cond

   task automatic stop_cond();
      sda_low <= 1'b1;
      tick(HALF / 2);
      scl <= 1'b1;
      tick(HALF);
      sda_low <= 1'b0;
      tick(HALF);
   endtask : stop_cond

   // wire is read late in the high phase, well after the device settles
   task automatic put_bit(input logic b, output logic got);
      sda_low <= ~b;
      tick(HALF / 2);
      scl <= 1'b1;
      tick(HALF);
      got = sda;
      scl <= 1'b0;
      tick(HALF / 2);
   endtask : put_bit

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic got;
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i], got);
      end
      put_bit(1'b1, got);
      ack = ~got;
   endtask : send_byte

   task automatic reg_write(input logic [6:0] addr, input logic [7:0] ptr,
                            input logic [7:0] data, output logic ack);
      logic a0;
      logic a1;
      logic a2;
      start_cond();
      send_byte({addr, 1'b0}, a0);
      send_byte(ptr, a1);
      send_byte(data, a2);
      stop_cond();
      ack = a0 & a1 & a2;
   endtask : reg_write

   // read byte: command, repeated start, one byte, master nack
   task automatic reg_read(input logic [6:0] addr, input logic [7:0] ptr,
                           output logic [7:0] data, output logic ack);
      logic a0;
      logic a1;
      logic a2;
      logic got;
      data = 8'h00;
      start_cond();
      send_byte({addr, 1'b0}, a0);
      ack = a0;
      if (a0) begin
         send_byte(ptr, a1);
         start_cond();
         send_byte({addr, 1'b1}, a2);
         ack = a0 & a1 & a2;
         for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, data[i]);
         end
         put_bit(1'b1, got);
      end
      stop_cond();
   endtask : reg_read

   // receive byte at the last pointer; a master ack repeats it once
   task automatic recv_twice(input logic [6:0] addr, output logic [7:0] d0,
                             output logic [7:0] d1, output logic ack);
      logic got;
      start_cond();
      send_byte({addr, 1'b1}, ack);
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, d0[i]);
      end
      put_bit(1'b0, got);
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, d1[i]);
      end
      put_bit(1'b1, got);
      stop_cond();
   endtask : recv_twice

endmodule : smbus_host

/* File: testbench/thermal_status_flags_test.sv */
`timescale 1ns/100ps
module thermal_status_flags_test;
   localparam logic [6:0] ADDR = thermal_pkg::ADDR_VARIANT_B;

   logic       clock;
   logic       rst_n;
   logic       conv_done;
   logic [2:0] conv_channel;
   logic       conv_alert;
   logic       conv_over;
   logic       conv_fault;
   logic       scl;
   logic       sda_low;
   logic       sda_oe;
   logic       ot_oe;
   logic       ot_out;
   logic       sda_out;
   logic [3:0] skip;
   wire logic  sda;
   int         fails;
   int         checked;
   logic [7:0] d;
   logic [7:0] d2;
   logic       ack;
   logic [3:0] want_skip;
   logic [6:0] others [3];

   // pulled up; low while either party pulls it
   assign sda = ~(sda_low | sda_oe);

   thermal_status_flags #(.SLAVE_ADDR(ADDR)) dut (
      .CLOCK              (clock),
      .RST_N              (rst_n),
      .SCL                (scl),
      .SDA_IN             (sda),
      .SDA_OUT            (sda_out),
      .SDA_OE             (sda_oe),
      .CONV_DONE          (conv_done),
      .CONV_CHANNEL       (conv_channel),
      .CONV_ALERT_HIGH    (conv_alert),
      .CONV_OVERTEMP_HIGH (conv_over),
      .CONV_DIODE_FAULT   (conv_fault),
      .OVERTEMP_OUTPUT    (ot_out),
      .OVERTEMP_OUTPUT_OE (ot_oe),
      .CHANNEL_SKIP       (skip)
   );

   smbus_host host (
      .clock   (clock),
      .sda     (sda),
      .scl     (scl),
      .sda_low (sda_low)
   );

   initial begin
      clock = 1'b0;
   end

   always begin
      #25 clock = ~clock;
   end

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic summarize();
      if (fails == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize

   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checked++;
      if (seen !== want) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic expect_reg(input logic [7:0] ptr, input logic [7:0] want);
      host.reg_read(ADDR, ptr, d, ack);
      check({7'h00, ack}, 8'h01);
      check(d, want);
   endtask : expect_reg

   task automatic write_cfg(input logic [7:0] value);
      host.reg_write(ADDR, thermal_pkg::OFFSET_CONFIG3, value, ack);
      check({7'h00, ack}, 8'h01);
   endtask : write_cfg

   // one result pulse, then wait until the pin outputs have followed
   task automatic conv(input logic [2:0] ch, input logic al, input logic ov,
                       input logic fa);
      @(posedge clock);
      conv_done <= 1'b1;
      conv_channel <= ch;
      conv_alert <= al;
      conv_over <= ov;
      conv_fault <= fa;
      @(posedge clock);
      conv_done <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
   endtask : conv

   initial begin
      repeat (80000) @(posedge clock);
      fails++;
      summarize();
   end

   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      fails = 0;
      checked = 0;
      rst_n = 1'b0;
      conv_done = 1'b0;
      conv_channel = 3'h0;
      conv_alert = 1'b0;
      conv_over = 1'b0;
      conv_fault = 1'b0;
      others = '{thermal_pkg::ADDR_VARIANT_A, thermal_pkg::ADDR_VARIANT_C,
                 thermal_pkg::ADDR_VARIANT_D};
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      #1;
      check({7'h00, ot_oe}, 8'h00);
      check({6'h00, sda_out, ot_out}, 8'h00);
      check({4'h0, skip}, 8'h00);
      expect_reg(thermal_pkg::OFFSET_DIODE_FAULT, 8'h60);
      expect_reg(thermal_pkg::OFFSET_OVERTEMP, 8'h00);
      expect_reg(thermal_pkg::OFFSET_STATUS1, 8'h00);
      expect_reg(thermal_pkg::OFFSET_CONFIG3, 8'h00);
      conv(3'h4, 1'b0, 1'b1, 1'b0);
      check({7'h00, ot_oe}, 8'h01);
      check({7'h00, ot_out}, 8'h00);
      expect_reg(thermal_pkg::OFFSET_OVERTEMP, 8'h08);
      conv(3'h1, 1'b0, 1'b1, 1'b0);
      expect_reg(thermal_pkg::OFFSET_OVERTEMP, 8'h09);
      expect_reg(thermal_pkg::OFFSET_OVERTEMP, 8'h09);
      conv(3'h2, 1'b0, 1'b1, 1'b0);
      conv(3'h4, 1'b0, 1'b0, 1'b0);
      expect_reg(thermal_pkg::OFFSET_OVERTEMP, 8'h01);
      check({7'h00, ot_oe}, 8'h01);
      write_cfg(8'h01);
      check({7'h00, ot_oe}, 8'h00);
      expect_reg(thermal_pkg::OFFSET_CONFIG3, 8'h01);
      conv(3'h4, 1'b0, 1'b1, 1'b0);
      check({7'h00, ot_oe}, 8'h01);
      write_cfg(8'h09);
      check({7'h00, ot_oe}, 8'h00);
      expect_reg(thermal_pkg::OFFSET_OVERTEMP, 8'h09);
      write_cfg(8'h00);
      check({7'h00, ot_oe}, 8'h01);
      for (int ch = 0; ch <= 4; ch++) begin
         conv(ch[2:0], 1'b1, 1'b0, 1'b0);
      end
      expect_reg(thermal_pkg::OFFSET_STATUS1, 8'h4f);
      expect_reg(thermal_pkg::OFFSET_OVERTEMP, 8'h00);
      conv(3'h2, 1'b0, 1'b0, 1'b0);
      expect_reg(thermal_pkg::OFFSET_STATUS1, 8'h4d);
      conv(3'h0, 1'b0, 1'b0, 1'b1);
      check({4'h0, skip}, 8'h00);
      want_skip = 4'h0;
      for (int k = 1; k <= 4; k++) begin
         conv(k[2:0], 1'b0, 1'b0, 1'b1);
         want_skip[k - 1] = 1'b1;
         check({4'h0, skip}, {4'h0, want_skip});
         expect_reg(thermal_pkg::OFFSET_DIODE_FAULT, {3'h3, want_skip, 1'b0});
      end
      conv(3'h3, 1'b0, 1'b0, 1'b0);
      check({4'h0, skip}, 8'h0b);
      expect_reg(thermal_pkg::OFFSET_DIODE_FAULT, 8'h76);
      for (int i = 0; i < 3; i++) begin
         host.reg_read(others[i], thermal_pkg::OFFSET_DIODE_FAULT, d, ack);
         check({7'h00, ack}, 8'h00);
      end
      expect_reg(8'h50, thermal_pkg::UNMAPPED_READ);
      expect_reg(thermal_pkg::OFFSET_DIODE_FAULT, 8'h76);
      host.recv_twice(ADDR, d, d2, ack);
      check({7'h00, ack}, 8'h01);
      check(d, 8'h76);
      check(d2, 8'h76);
      summarize();
   end

endmodule : thermal_status_flags_test
